// >>> hw/tdx_pkg.sv
package tdx_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BASE = 8'h04;
    localparam logic [7:0] OFS_IRQ_CTRL = 8'h08;
    localparam logic [7:0] OFS_SAVED_IRQ = 8'h0C;
    localparam logic [7:0] OFS_SYSCFG = 8'h10;
    localparam logic [7:0] OFS_LAST = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;
    // control field positions
    localparam int CTRL_MMU_POS = 0;
    localparam int CTRL_FPU_POS = 1;
    localparam int CTRL_COP_POS = 2;
    localparam int CTRL_OPERAND_POS = 3;
    localparam int CTRL_CORE_REG_POS = 4;
    localparam int CTRL_SAVE_AREA_POS = 5;
    localparam int CTRL_SCR_POS = 6;
    localparam int CTRL_BITS = 7;
    localparam int CPN_POS = 8;
    localparam int LAST_ID_POS = 8;
    // reset values
    localparam logic [CTRL_BITS-1:0] CTRL_RST = 7'h78;
    localparam logic [31:0] BASE_RST = 32'h0000_0000;
    localparam logic IRQ_EN_RST = 1'b0;
    localparam logic [7:0] CPN_RST = 8'h00;
    // trap identifiers
    localparam logic [2:0] CLASS_PROT = 3'h1;
    localparam logic [2:0] CLASS_INSTR = 3'h2;
    localparam logic [2:0] CLASS_CTX = 3'h3;
    localparam logic [7:0] ID_GREG_WRITE = 8'h07;
    localparam logic [7:0] ID_ILLEGAL_OP = 8'h01;
    localparam logic [7:0] ID_UNIMPL_OP = 8'h02;
    localparam logic [7:0] ID_BAD_OPERAND = 8'h03;
    localparam logic [7:0] ID_ALIGN = 8'h04;
    localparam logic [7:0] ID_MEM_ADDR = 8'h05;
    localparam logic [7:0] ID_DEPLETION = 8'h01;
    localparam logic [7:0] ID_DEPTH_OVER = 8'h02;
    localparam logic [7:0] ID_DEPTH_UNDER = 8'h03;
    localparam logic [7:0] ID_FREE_UNDER = 8'h04;
    localparam logic [7:0] ID_STACK_UNDER = 8'h05;
    localparam logic [7:0] ID_CTX_TYPE = 8'h06;
    localparam int CLASS_SHIFT = 5;
    localparam int SEG_MSB = 31;
    localparam int SEG_LSB = 28;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_DEPL = 2'h1
    } tdx_state_type;

    typedef struct packed {
        logic [31:0] pc;
        logic [31:0] resume_pc;
        logic opcode_known;
        logic need_mmu;
        logic need_fpu;
        logic need_cop;
        logic pair_operand;
        logic pair_odd;
        logic gaddr_write;
        logic gaddr_perm;
        logic mem_access;
        logic misaligned;
        logic circ_bad;
        logic [31:0] base_addr;
        logic [31:0] ea_addr;
        logic [31:0] end_addr;
        logic core_reg_hit;
        logic save_area_bad;
        logic scratch_out;
        logic is_call;
        logic is_ret;
        logic depth_en;
        logic [6:0] depth_count;
        logic [6:0] depth_max;
        logic ctx_save;
        logic entry_save;
        logic restore_lower;
        logic restore_upper;
        logic ctx_error;
        logic upper_lower_flag;
        logic [31:0] save_addr;
        logic [31:0] free_list_head_pointer;
        logic [31:0] context_limit_pointer;
        logic [31:0] previous_context_pointer;
    } tdx_req_type;

    typedef struct packed {
        logic valid;
        logic [2:0] trap_class_number;
        logic [7:0] trap_ident_number;
        logic [31:0] entry;
        logic [31:0] ret;
    } tdx_trap_type;
endpackage

// >>> hw/tdx_trap_detect.sv
// Notes on behaviour
// - writing address registers 0,1,8,9 without permission raises trap ident 7.
// - instruction errors report under trap class 2.
// - opcode unknown to the core raises ident 1.
// - known instruction whose unit is absent raises ident 2.
// - odd register for a pair operand may raise ident 3, switchable.
// - misaligned data address or bad circular buffer raises ident 4.
// - effective address leaving the base segment raises ident 5.
// - object spanning two segments raises ident 5.
// - optional ident 5 for core register, save area or scratch range faults.
// - context save and restore faults report under trap class 3.
// - save into the limit-pointed area completes, then ident 1 depletion trap.
// - depletion during entry returns to the original handler's first instruction.
// - every depletion trap sets the depletion seen flag.
// - call at maximum depth with counting enabled raises ident 2.
// - return at zero depth with counting enabled raises ident 3.
// - save with null free list head raises ident 4.
// - any save or restore error abandons it, ident 4 into register fifteen.
// - restore with null previous context pointer raises ident 5.
// - restore of wrong context type raises ident 6.
// - entry is base OR class shifted left five; ident goes to register fifteen.
// - trap entry clears interrupt enable, saving enable and priority.
// - free list underflow beats every other request trap; only a pending depletion trap goes first.
`timescale 1ns/10ps
`default_nettype none
module tdx_trap_detect #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic req_valid,
    output logic req_ready,
    input wire tdx_pkg::tdx_req_type req,
    output tdx_pkg::tdx_trap_type trap,
    output logic [31:0] data_register_fifteen,
    output logic global_interrupt_enable,
    output logic depletion_seen_flag
);
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
        $error("ADDR_W must lie between 5 and 32");
    end

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic seg_diff(input logic [31:0] a, input logic [31:0] b);
        return a[tdx_pkg::SEG_MSB:tdx_pkg::SEG_LSB] != b[tdx_pkg::SEG_MSB:tdx_pkg::SEG_LSB];
    endfunction

    logic [tdx_pkg::CTRL_BITS-1:0] ctrl_ff;
    logic [31:0] base_ff;
    logic irq_en_ff;
    logic [7:0] irq_prio_ff;
    logic saved_en_ff;
    logic [7:0] saved_prio_ff;
    logic seen_ff;
    logic [2:0] last_class_ff;
    logic [7:0] last_ident_ff;
    logic [31:0] count_ff;
    logic bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    tdx_pkg::tdx_state_type state_ff, nxt_state;
    logic [31:0] depl_ret_ff;
    tdx_pkg::tdx_trap_type trap_ff, nxt_trap;

    // bus write: both channels taken in one cycle, one write outstanding
    logic wr_go, rd_go;
    logic [7:0] wa, ra;
    assign wa = 8'(awaddr & ADDR_W'('hFC));
    assign ra = 8'(araddr & ADDR_W'('hFC));
    assign wr_go = awvalid && wvalid && !bvalid_ff;
    assign rd_go = arvalid && !rvalid_ff;
    assign awready = wr_go;
    assign wready = wr_go;
    assign arready = rd_go;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = rdata_ff;

    function automatic logic mapped(input logic [7:0] a);
        return a <= tdx_pkg::OFS_COUNT;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= tdx_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= mapped(wa) ? tdx_pkg::RESP_OKAY : tdx_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= tdx_pkg::RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= mapped(ra) ? tdx_pkg::RESP_OKAY : tdx_pkg::RESP_SLVERR;
            case (ra)
                tdx_pkg::OFS_CTRL: rdata_ff <= 32'(ctrl_ff);
                tdx_pkg::OFS_BASE: rdata_ff <= base_ff;
                tdx_pkg::OFS_IRQ_CTRL: rdata_ff <= {16'h0000, irq_prio_ff, 7'h00, irq_en_ff};
                tdx_pkg::OFS_SAVED_IRQ: rdata_ff <= {16'h0000, saved_prio_ff, 7'h00, saved_en_ff};
                tdx_pkg::OFS_SYSCFG: rdata_ff <= {31'h0000_0000, seen_ff};
                tdx_pkg::OFS_LAST: rdata_ff <= {16'h0000, last_ident_ff, 5'h00, last_class_ff};
                tdx_pkg::OFS_COUNT: rdata_ff <= count_ff;
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    logic [31:0] ctrl_w, base_w, irq_w, sys_w;
    assign ctrl_w = wmerge(32'(ctrl_ff), wdata, wstrb);
    assign base_w = wmerge(base_ff, wdata, wstrb);
    assign irq_w = wmerge({16'h0000, irq_prio_ff, 7'h00, irq_en_ff}, wdata, wstrb);
    assign sys_w = wmerge(32'h0000_0000, wdata, wstrb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= tdx_pkg::CTRL_RST;
            base_ff <= tdx_pkg::BASE_RST;
        end else if (wr_go && wa == tdx_pkg::OFS_CTRL) begin
            ctrl_ff <= ctrl_w[tdx_pkg::CTRL_BITS-1:0];
        end else if (wr_go && wa == tdx_pkg::OFS_BASE) begin
            // bit 0 of the base is fixed at zero, handlers are halfword aligned
            base_ff <= {base_w[31:1], 1'b0};
        end
    end

    // trap detection for the offered request
    logic save_fault, fire;
    always_comb begin
        nxt_trap = '0;
        save_fault = (req.ctx_save && req.free_list_head_pointer == 32'h0000_0000) ||
                     ((req.ctx_save || req.restore_lower || req.restore_upper) && req.ctx_error);
        if (state_ff == tdx_pkg::ST_DEPL) begin
            nxt_trap.valid = 1'b1;
            nxt_trap.trap_class_number = tdx_pkg::CLASS_CTX;
            nxt_trap.trap_ident_number = tdx_pkg::ID_DEPLETION;
            nxt_trap.ret = depl_ret_ff;
        end else if (req_valid) begin
            nxt_trap.valid = 1'b1;
            nxt_trap.ret = req.pc;
            if (save_fault) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_CTX;
                nxt_trap.trap_ident_number = tdx_pkg::ID_FREE_UNDER;
            end else if (!req.opcode_known) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_INSTR;
                nxt_trap.trap_ident_number = tdx_pkg::ID_ILLEGAL_OP;
            end else if ((req.need_mmu && !ctrl_ff[tdx_pkg::CTRL_MMU_POS]) ||
                         (req.need_fpu && !ctrl_ff[tdx_pkg::CTRL_FPU_POS]) ||
                         (req.need_cop && !ctrl_ff[tdx_pkg::CTRL_COP_POS])) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_INSTR;
                nxt_trap.trap_ident_number = tdx_pkg::ID_UNIMPL_OP;
            end else if (ctrl_ff[tdx_pkg::CTRL_OPERAND_POS] && req.pair_operand && req.pair_odd) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_INSTR;
                nxt_trap.trap_ident_number = tdx_pkg::ID_BAD_OPERAND;
            end else if ((req.restore_lower || req.restore_upper) &&
                         req.previous_context_pointer == 32'h0000_0000) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_CTX;
                nxt_trap.trap_ident_number = tdx_pkg::ID_STACK_UNDER;
            end else if ((req.restore_lower && req.upper_lower_flag) ||
                         (req.restore_upper && !req.upper_lower_flag)) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_CTX;
                nxt_trap.trap_ident_number = tdx_pkg::ID_CTX_TYPE;
            end else if (req.is_call && req.depth_en && req.depth_count == req.depth_max) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_CTX;
                nxt_trap.trap_ident_number = tdx_pkg::ID_DEPTH_OVER;
            end else if (req.is_ret && req.depth_en && req.depth_count == 7'h00) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_CTX;
                nxt_trap.trap_ident_number = tdx_pkg::ID_DEPTH_UNDER;
            end else if (req.mem_access && (req.misaligned || req.circ_bad)) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_INSTR;
                nxt_trap.trap_ident_number = tdx_pkg::ID_ALIGN;
            end else if (req.mem_access && (seg_diff(req.base_addr, req.ea_addr) ||
                         seg_diff(req.ea_addr, req.end_addr) ||
                         (req.core_reg_hit && ctrl_ff[tdx_pkg::CTRL_CORE_REG_POS]) ||
                         (req.save_area_bad && ctrl_ff[tdx_pkg::CTRL_SAVE_AREA_POS]) ||
                         (req.scratch_out && ctrl_ff[tdx_pkg::CTRL_SCR_POS]))) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_INSTR;
                nxt_trap.trap_ident_number = tdx_pkg::ID_MEM_ADDR;
            end else if (req.gaddr_write && !req.gaddr_perm) begin
                nxt_trap.trap_class_number = tdx_pkg::CLASS_PROT;
                nxt_trap.trap_ident_number = tdx_pkg::ID_GREG_WRITE;
            end else begin
                nxt_trap.valid = 1'b0;
            end
        end
        nxt_trap.entry = base_ff | (32'(nxt_trap.trap_class_number) << tdx_pkg::CLASS_SHIFT);
    end
    assign fire = nxt_trap.valid;
    assign req_ready = state_ff == tdx_pkg::ST_IDLE;

    // a clean save into the limit-pointed area finishes, the depletion trap follows
    logic depl_hit;
    assign depl_hit = req_valid && req_ready && !fire && req.ctx_save &&
                      req.save_addr == req.context_limit_pointer;

    always_comb begin
        case (state_ff)
            tdx_pkg::ST_IDLE: nxt_state = depl_hit ? tdx_pkg::ST_DEPL : tdx_pkg::ST_IDLE;
            tdx_pkg::ST_DEPL: nxt_state = tdx_pkg::ST_IDLE;
            default: nxt_state = tdx_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= tdx_pkg::ST_IDLE;
            depl_ret_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            if (depl_hit) begin
                // pipeline already hands over the handler's first instruction for entry saves
                depl_ret_ff <= req.resume_pc;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trap_ff <= '0;
            data_register_fifteen <= 32'h0000_0000;
            last_class_ff <= 3'h0;
            last_ident_ff <= 8'h00;
            count_ff <= 32'h0000_0000;
        end else begin
            trap_ff <= nxt_trap;
            if (fire) begin
                data_register_fifteen <= 32'(nxt_trap.trap_ident_number);
                last_class_ff <= nxt_trap.trap_class_number;
                last_ident_ff <= nxt_trap.trap_ident_number;
                count_ff <= count_ff + 32'h0000_0001;
            end
        end
    end
    assign trap = trap_ff;

    // trap entry beats a software write to the enable in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_ff <= tdx_pkg::IRQ_EN_RST;
            irq_prio_ff <= tdx_pkg::CPN_RST;
            saved_en_ff <= 1'b0;
            saved_prio_ff <= 8'h00;
        end else if (fire) begin
            irq_en_ff <= 1'b0;
            saved_en_ff <= irq_en_ff;
            saved_prio_ff <= irq_prio_ff;
        end else if (wr_go && wa == tdx_pkg::OFS_IRQ_CTRL) begin
            irq_en_ff <= irq_w[0];
            irq_prio_ff <= irq_w[tdx_pkg::CPN_POS +: 8];
        end
    end
    assign global_interrupt_enable = irq_en_ff;

    // write one to clear; a depletion trap in the same cycle keeps it set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_ff <= 1'b0;
        end else if (state_ff == tdx_pkg::ST_DEPL) begin
            seen_ff <= 1'b1;
        end else if (wr_go && wa == tdx_pkg::OFS_SYSCFG && sys_w[0]) begin
            seen_ff <= 1'b0;
        end
    end
    assign depletion_seen_flag = seen_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_underflow_first: assert property (req_valid && req_ready && save_fault |=> trap.valid &&
        trap.trap_ident_number == tdx_pkg::ID_FREE_UNDER && trap.trap_class_number == tdx_pkg::CLASS_CTX)
        else $error("free list underflow not taken first");
    a_illegal_ident: assert property (req_valid && req_ready && !save_fault && !req.opcode_known |=>
        trap.trap_ident_number == tdx_pkg::ID_ILLEGAL_OP && trap.trap_class_number == tdx_pkg::CLASS_INSTR)
        else $error("illegal opcode trap wrong");
    a_entry_addr: assert property (trap.valid |->
        trap.entry == ($past(base_ff) | (32'(trap.trap_class_number) << tdx_pkg::CLASS_SHIFT)))
        else $error("handler entry address wrong");
    a_reg15_ident: assert property (trap.valid |-> data_register_fifteen == 32'(trap.trap_ident_number))
        else $error("ident not in register fifteen");
    a_depl_follows: assert property (depl_hit |=> !trap.valid ##1 (trap.valid &&
        trap.trap_ident_number == tdx_pkg::ID_DEPLETION && trap.trap_class_number == tdx_pkg::CLASS_CTX))
        else $error("depletion trap not one cycle after save");
    a_depl_ret: assert property (depl_hit |-> ##2 trap.ret == $past(req.resume_pc, 2))
        else $error("depletion return address wrong");
    a_seen_set: assert property (state_ff == tdx_pkg::ST_DEPL |=> depletion_seen_flag)
        else $error("depletion seen flag not set");
    a_ie_cleared: assert property (fire |=> !global_interrupt_enable &&
        saved_en_ff == $past(irq_en_ff) && saved_prio_ff == $past(irq_prio_ff))
        else $error("interrupts not disabled on entry");
    a_no_depth_off: assert property (req_valid && req_ready && !req.depth_en |=>
        !(trap.valid && trap.trap_class_number == tdx_pkg::CLASS_CTX &&
          (trap.trap_ident_number == tdx_pkg::ID_DEPTH_OVER || trap.trap_ident_number == tdx_pkg::ID_DEPTH_UNDER)))
        else $error("depth trap with counting off");
    a_greg_write_trap: assert property (req_valid && req_ready && !save_fault && req.opcode_known &&
        req.gaddr_write && !req.gaddr_perm |=> trap.valid)
        else $error("global register write not trapped");

    c_depletion: cover property (depl_hit ##2 trap.valid);
    c_underflow: cover property (req_valid && save_fault);
    c_seen_clear: cover property (depletion_seen_flag ##1 !depletion_seen_flag);
    c_unmapped: cover property (bvalid && bresp == tdx_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

// >>> tb/tdx_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
module tdx_pipe_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic [3:0] delay,
    input wire tdx_pkg::tdx_req_type req_in,
    input wire logic req_ready,
    output logic req_valid,
    output tdx_pkg::tdx_req_type req,
    output logic busy
);
    logic [3:0] wait_ff;
    // idle request bus shows the inverse of the last request; during the delay it shows the last request again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_valid <= 1'b0;
            busy <= 1'b0;
            wait_ff <= 4'h0;
            req <= '0;
        end else if (go && !busy) begin
            busy <= 1'b1;
            wait_ff <= delay;
            req <= tdx_pkg::tdx_req_type'(~req);
        end else if (busy && !req_valid) begin
            if (wait_ff == 4'h0) begin
                req_valid <= 1'b1;
                req <= req_in;
            end else begin
                wait_ff <= wait_ff - 4'h1;
            end
        end else if (req_valid && req_ready) begin
            req_valid <= 1'b0;
            busy <= 1'b0;
            req <= tdx_pkg::tdx_req_type'(~req_in);
        end
    end
endmodule
`default_nettype wire

// >>> tb/tdx_trap_detect_test.sv
`timescale 1ns/10ps
`default_nettype none
module tdx_trap_detect_test;
    localparam int NC = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, go = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, req_valid, req_ready, gie, dsf, busy;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, reg15;
    logic [1:0] bresp, rresp;
    logic [3:0] dly = 4'h0;
    tdx_pkg::tdx_req_type req, req_in = '0, r;
    tdx_pkg::tdx_trap_type trap;
    int err_count = 0;
    int n_tests = 0;
    logic seen;
    logic [31:0] base = 32'h8000_1000;
    logic [2:0] e_class [NC] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2,
        3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h0};
    logic [7:0] e_ident [NC] = '{8'h07, 8'h01, 8'h02, 8'h02, 8'h02, 8'h03, 8'h04, 8'h04, 8'h05, 8'h05,
        8'h05, 8'h02, 8'h03, 8'h04, 8'h04, 8'h05, 8'h06, 8'h06, 8'h01, 8'h00};

    always #12.5 aclk = ~aclk;

    tdx_trap_detect #(.ADDR_W(8)) DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .trap(trap), .data_register_fifteen(reg15),
        .global_interrupt_enable(gie), .depletion_seen_flag(dsf));

    tdx_pipe_model pipe (.aclk(aclk), .aresetn(aresetn), .go(go), .delay(dly), .req_in(req_in),
        .req_ready(req_ready), .req_valid(req_valid), .req(req), .busy(busy));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!(awready && wready) && ++n < 50);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (!bvalid && ++n < 50);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        @(posedge aclk);
        if (n >= 50) err_count++;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready && ++n < 50);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid && ++n < 50);
        chk(nm, e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        @(posedge aclk);
        if (n >= 50) err_count++;
    endtask

    function automatic tdx_pkg::tdx_req_type mk(input int i);
        tdx_pkg::tdx_req_type q;
        q = '0;
        q.pc = 32'h8000_0000 + 32'(i * 4);
        q.resume_pc = 32'h8000_4000;
        q.opcode_known = 1'b1;
        q.base_addr = 32'h8000_2000;
        q.ea_addr = 32'h8000_2000;
        q.end_addr = 32'h8000_2003;
        q.depth_max = 7'h3F;
        q.depth_count = 7'h10;
        q.save_addr = 32'h8001_0100;
        q.free_list_head_pointer = 32'h8001_0000;
        q.context_limit_pointer = 32'h8001_0040;
        q.previous_context_pointer = 32'h8001_0080;
        q.mem_access = (i >= 6 && i <= 10);
        q.depth_en = (i == 11 || i == 12);
        q.restore_lower = (i >= 14 && i <= 16);
        q.ctx_save = (i == 13 || i == 18);
        case (i)
            0: q.gaddr_write = 1'b1;
            1: q.opcode_known = 1'b0;
            2: q.need_mmu = 1'b1;
            3: q.need_fpu = 1'b1;
            4: q.need_cop = 1'b1;
            5: q.pair_odd = 1'b1;
            6: q.misaligned = 1'b1;
            7: q.circ_bad = 1'b1;
            8: q.ea_addr = 32'h9000_0000;
            9: q.end_addr = 32'h9000_0001;
            10: q.core_reg_hit = 1'b1;
            11: q.depth_count = 7'h3F;
            12: q.depth_count = 7'h00;
            13: q.free_list_head_pointer = 32'h0;
            14: q.ctx_error = 1'b1;
            15: q.previous_context_pointer = 32'h0;
            16: q.upper_lower_flag = 1'b1;
            17: q.restore_upper = 1'b1;
            18: q.save_addr = 32'h8001_0040;
            default: q.is_call = 1'b1;
        endcase
        q.pair_operand = (i == 5);
        q.is_call = q.is_call || (i == 11);
        q.is_ret = (i == 12);
        q.entry_save = (i == 18);
        q.opcode_known = q.opcode_known && (i != 13);
        if (i == 19) q.depth_count = 7'h3F;
        return q;
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk("ctrl", tdx_pkg::OFS_CTRL, 32'h0000_0078, 2'h0);
        rd_chk("syscfg", tdx_pkg::OFS_SYSCFG, 32'h0, 2'h0);
        rd_chk("unmapped", 8'h1C, 32'h0, 2'h2);
        wr(8'h20, 32'hFFFF_FFFF, 2'h2);
        wr(tdx_pkg::OFS_BASE, 32'h8000_1001, 2'h0);
        rd_chk("base", tdx_pkg::OFS_BASE, base, 2'h0);
        wr(tdx_pkg::OFS_IRQ_CTRL, 32'h0000_5A01, 2'h0);
        $display("register test done");
        for (int i = 0; i < NC; i++) begin
            r = mk(i);
            req_in <= r;
            dly <= 4'(i % 3);
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
            seen = 1'b0;
            for (int n = 0; n < 12 && !seen; n++) begin
                @(posedge aclk);
                #1;
                if (trap.valid === 1'b1) seen = 1'b1;
                if (i == 18 && n == 1) chk("req_ready", 32'h0, {31'h0, req_ready});
            end
            chk("trap_valid", {31'h0, e_ident[i] != 8'h00}, {31'h0, seen});
            if (seen) begin
                chk("class", {29'h0, e_class[i]}, {29'h0, trap.trap_class_number});
                chk("ident", {24'h0, e_ident[i]}, {24'h0, trap.trap_ident_number});
                chk("entry", base | {24'h0, e_class[i], 5'h0}, trap.entry);
                chk("ret", (i == 18) ? r.resume_pc : r.pc, trap.ret);
                @(posedge aclk);
                #1;
                chk("reg15", {24'h0, e_ident[i]}, reg15);
                chk("gie", 32'h0, {31'h0, gie});
            end
            for (int n = 0; n < 20 && busy; n++) @(posedge aclk);
            @(posedge aclk);
            if (i == 0) begin
                rd_chk("saved_ctx", tdx_pkg::OFS_SAVED_IRQ, 32'h0000_5A01, 2'h0);
                rd_chk("irq_ctrl", tdx_pkg::OFS_IRQ_CTRL, 32'h0000_5A00, 2'h0);
            end
            if (i == 18) begin
                chk("seen_flag", 32'h1, {31'h0, dsf});
                rd_chk("syscfg", tdx_pkg::OFS_SYSCFG, 32'h1, 2'h0);
                wr(tdx_pkg::OFS_SYSCFG, 32'h1, 2'h0);
                rd_chk("syscfg", tdx_pkg::OFS_SYSCFG, 32'h0, 2'h0);
            end
            $display("test %0d done", i);
        end
        rd_chk("last", tdx_pkg::OFS_LAST, 32'h0000_0103, 2'h0);
        rd_chk("count", tdx_pkg::OFS_COUNT, 32'h0000_0013, 2'h0);
        summarize();
    end
endmodule
`default_nettype wire
